//--- logic/ehfp_pkg.sv
/*
  Shared constants for the external host flash programming port: command
  codes, address positions, identity bytes and operation timing.
  Assumes both ends run on one 200 MHz clock and share this package.
*/
// Contract
// - Strobe falling with reset high enters mode
// - Mode held only while reset high, strobe low
// - Commands ignored until identify read arms
// - Port zero is bidirectional data bus
// - Port one carries address bits 7..0
// - Port two/three pins carry address 15..8
// - Command from four pins plus control pins
// - Port three pin 3 is ready/busy output
// - Device times all operations internally
// - Exactly twelve decoded hardware commands
// - Erase/program launched on program pulse fall
// - Host drives only listed pin combinations
// - Identify read: pulse high, command 0000
// - Erase and program codes with access high
// - Byte verify: command 1100, data out
// - Lock and remap bit writes ignore address
// - Block erase target from address 15..12
// - Identify at 30H maker, 31H device
// - Busy low while operation runs
// - Oscillator runs and core held in mode
package ehfp_pkg;
  // Command codes {P3[7],P3[6],P2[7],P2[6]}
  localparam logic [3:0] EHFP_CMD_ID     = 4'h0;
  localparam logic [3:0] EHFP_CMD_CHIP   = 4'h1;
  localparam logic [3:0] EHFP_CMD_BLOCK  = 4'hD;
  localparam logic [3:0] EHFP_CMD_SECTOR = 4'hB;
  localparam logic [3:0] EHFP_CMD_BYTE   = 4'hE;
  localparam logic [3:0] EHFP_CMD_BURST  = 4'h6;
  localparam logic [3:0] EHFP_CMD_VERIFY = 4'hC;
  localparam logic [3:0] EHFP_CMD_SB1    = 4'hF;
  localparam logic [3:0] EHFP_CMD_SB2    = 4'h3;
  localparam logic [3:0] EHFP_CMD_SB3    = 4'h5;
  localparam logic [3:0] EHFP_CMD_RB0    = 4'h8;
  localparam logic [3:0] EHFP_CMD_RB1    = 4'h9;
  // Identity addresses and arbitrary stand-in identity values
  localparam logic [15:0] EHFP_ID_MAKER_ADDR = 16'h0030;
  localparam logic [15:0] EHFP_ID_DEV_ADDR   = 16'h0031;
  localparam logic [7:0]  EHFP_ID_MAKER      = 8'h5A; // Arbitrary value
  localparam logic [7:0]  EHFP_ID_DEV        = 8'hA5; // Arbitrary value
  // Block select on address bits 15..12
  localparam int          EHFP_BLK_LSB   = 12;
  localparam logic [3:0]  EHFP_BLK_SEC   = 4'hF;
  localparam logic [15:0] EHFP_ERASED    = 16'h00FF;
  // Operation time and derived cycles at 200 MHz
  localparam int EHFP_CLK_MHZ      = 200;
  localparam int EHFP_OP_TIME_US   = 20;
  localparam int EHFP_OP_CYCLES    = EHFP_OP_TIME_US * EHFP_CLK_MHZ;
  localparam int EHFP_OP_CNT_W     = 16;
endpackage

//--- logic/ehfp_if.sv
/*
  Pin bundle between the programming host and the device port.
  Port zero is two-way: the interface resolves its level from both enables.
*/
`timescale 1ns/100ps
interface ehfp_if;
  logic       rst_pin;            // Device reset pin, high in mode
  logic       host_mode_strobe_n;
  logic       prog_pulse_n;
  logic       ext_access_n;
  logic [7:0] port_one;
  logic [7:0] port_two;
  logic [7:0] port_three_in;      // Host to device, bit 3 unused
  logic       ready_busy;         // Device drives port three pin 3
  logic [7:0] port_zero_h;        // Host data out
  logic       port_zero_h_oe;
  logic [7:0] port_zero_d;        // Device data out
  logic       port_zero_d_oe;
  logic [7:0] port_zero;          // Resolved bus level

  // Pull-up when nobody drives
  assign port_zero = port_zero_d_oe ? port_zero_d : (port_zero_h_oe ? port_zero_h : 8'hFF);

  modport device (
    input  rst_pin, host_mode_strobe_n, prog_pulse_n, ext_access_n,
    input  port_one, port_two, port_three_in, port_zero,
    output ready_busy, port_zero_d, port_zero_d_oe
  );
  modport host (
    output rst_pin, host_mode_strobe_n, prog_pulse_n, ext_access_n,
    output port_one, port_two, port_three_in, port_zero_h, port_zero_h_oe,
    input  ready_busy, port_zero
  );
endinterface

//--- logic/ehfp_device.sv
/*
  Device end: mode entry, arming, command decode, self-timed flash model,
  ready/busy and data drive. Assumes the host keeps the legal pin codes and
  all pins are asynchronous to SYS_CLK.
*/
`timescale 1ns/100ps
module ehfp_device
  import ehfp_pkg::*;
#(
  parameter int OP_CYCLES = EHFP_OP_CYCLES,
  parameter int MEM_DEPTH = 64
) (
  input  wire logic SYS_CLK,
  input  wire logic NRST,
  ehfp_if.device    PINS,
  output logic      OSC_EN,
  output logic      CORE_RESET,
  output logic      MODE_ACTIVE,
  output logic      ARMED,
  output logic [2:0] LOCK_BITS,
  output logic [1:0] REMAP_BITS
);
  localparam int AW = $clog2(MEM_DEPTH);

  typedef enum logic [1:0] {EHFP_IDLE, EHFP_BUSY} ehfp_dstate_t;

  //////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on every pin
  logic [1:0]  rst_s_q, strb_s_q, prog_s_q, ea_s_q;
  logic [7:0]  p1_a_q, p1_b_q, p2_a_q, p2_b_q, p3_a_q, p3_b_q, p0_a_q, p0_b_q;
  logic        strb_prev_q, prog_prev_q;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rst_s_q  <= 2'h0;
      strb_s_q <= 2'h3;
      prog_s_q <= 2'h3;
      ea_s_q   <= 2'h0;
      p0_a_q   <= 8'h00;
      p0_b_q   <= 8'h00;
      p1_a_q   <= 8'h00;
      p1_b_q   <= 8'h00;
      p2_a_q   <= 8'h00;
      p2_b_q   <= 8'h00;
      p3_a_q   <= 8'h00;
      p3_b_q   <= 8'h00;
    end else begin
      rst_s_q  <= {rst_s_q[0], PINS.rst_pin};
      strb_s_q <= {strb_s_q[0], PINS.host_mode_strobe_n};
      prog_s_q <= {prog_s_q[0], PINS.prog_pulse_n};
      ea_s_q   <= {ea_s_q[0], PINS.ext_access_n};
      p0_a_q   <= PINS.port_zero;
      p0_b_q   <= p0_a_q;
      p1_a_q   <= PINS.port_one;
      p1_b_q   <= p1_a_q;
      p2_a_q   <= PINS.port_two;
      p2_b_q   <= p2_a_q;
      p3_a_q   <= PINS.port_three_in;
      p3_b_q   <= p3_a_q;
    end
  end

  // Edge history only looks at second-stage values
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      strb_prev_q <= 1'b1;
      prog_prev_q <= 1'b1;
    end else begin
      strb_prev_q <= strb_s_q[1];
      prog_prev_q <= prog_s_q[1];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin decode
  logic        strb_fall, prog_fall, hold_ok;
  logic [15:0] addr;
  logic [3:0]  cmd;
  logic [AW-1:0] idx;

  assign strb_fall = strb_prev_q && !strb_s_q[1];
  assign prog_fall = prog_prev_q && !prog_s_q[1];
  assign hold_ok   = rst_s_q[1] && !strb_s_q[1];
  assign addr      = {p3_b_q[5], p3_b_q[4], p2_b_q[5:0], p1_b_q};
  assign cmd       = {p3_b_q[7], p3_b_q[6], p2_b_q[7], p2_b_q[6]};
  assign idx       = addr[AW-1:0];

  //////////////////////////////////////////////////////////////////////
  // Mode entry and exit
  logic mode_q;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      mode_q <= 1'b0;
    end else if (!hold_ok) begin
      mode_q <= 1'b0;
    end else if (strb_fall) begin
      mode_q <= 1'b1;
    end
  end

  // Arming by identify read, lost on exit
  logic armed_q;
  logic id_read;
  assign id_read = mode_q && prog_s_q[1] && cmd == EHFP_CMD_ID && ea_s_q[1];
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !mode_q) begin
      armed_q <= 1'b0;
    end else if (id_read) begin
      armed_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Self-timed operation sequencer
  ehfp_dstate_t st_q;
  logic [EHFP_OP_CNT_W-1:0] cnt_q;
  logic [3:0]  op_q;
  logic [15:0] op_addr_q;
  logic [7:0]  op_data_q;
  logic        launch, valid_cmd;

  // Only the ten pulse-launched codes start work
  always_comb begin
    case (cmd)
      EHFP_CMD_CHIP, EHFP_CMD_BLOCK, EHFP_CMD_SECTOR, EHFP_CMD_BYTE,
      EHFP_CMD_BURST, EHFP_CMD_SB1, EHFP_CMD_SB2, EHFP_CMD_SB3,
      EHFP_CMD_RB0, EHFP_CMD_RB1: valid_cmd = 1'b1;
      default: valid_cmd = 1'b0;
    endcase
  end
  assign launch = mode_q && armed_q && prog_fall && ea_s_q[1] && valid_cmd && st_q == EHFP_IDLE;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !mode_q) begin
      st_q      <= EHFP_IDLE;
      cnt_q     <= '0;
      op_q      <= 4'h0;
      op_addr_q <= 16'h0000;
      op_data_q <= 8'h00;
    end else begin
      case (st_q)
        EHFP_IDLE: begin
          if (launch) begin
            st_q      <= EHFP_BUSY;
            cnt_q     <= EHFP_OP_CNT_W'(OP_CYCLES - 1);
            op_q      <= cmd;
            op_addr_q <= addr;
            op_data_q <= p0_b_q;
          end
        end
        EHFP_BUSY: begin
          if (cnt_q == '0) begin
            st_q <= EHFP_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: st_q <= EHFP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Flash array and lock/remap bits, written when the operation ends
  logic [7:0] mem_q [MEM_DEPTH];
  logic       done;
  logic       blk_sec;
  logic [2:0] lock_q;
  logic [1:0] remap_q;
  assign done    = st_q == EHFP_BUSY && cnt_q == '0;
  assign blk_sec = op_addr_q[15:EHFP_BLK_LSB] == EHFP_BLK_SEC;

  // Array modelled as a window of the low address bits
  generate
    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_cell
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          mem_q[i] <= EHFP_ERASED[7:0];
        end else if (done) begin
          if (op_q == EHFP_CMD_CHIP) begin
            mem_q[i] <= EHFP_ERASED[7:0];
          end else if ((op_q == EHFP_CMD_BLOCK || op_q == EHFP_CMD_SECTOR) && !blk_sec
                       && !op_addr_q[15] && lock_q == 3'h0) begin
            // Window is smaller than a primary sector, so a sector erase clears it all
            mem_q[i] <= EHFP_ERASED[7:0];
          end else if ((op_q == EHFP_CMD_BYTE || op_q == EHFP_CMD_BURST)
                       && op_addr_q[AW-1:0] == AW'(i) && lock_q == 3'h0) begin
            mem_q[i] <= op_data_q;
          end
        end
      end
    end
  endgenerate

  // Lock and remap writes; chip erase clears them
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      lock_q  <= 3'h0;
      remap_q <= 2'h0;
    end else if (done) begin
      case (op_q)
        EHFP_CMD_CHIP: begin
          lock_q  <= 3'h0;
          remap_q <= 2'h0;
        end
        EHFP_CMD_SB1: lock_q[0]  <= 1'b1;
        EHFP_CMD_SB2: lock_q[1]  <= 1'b1;
        EHFP_CMD_SB3: lock_q[2]  <= 1'b1;
        EHFP_CMD_RB0: remap_q[0] <= 1'b1;
        EHFP_CMD_RB1: remap_q[1] <= 1'b1;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data path: identify and verify drive port zero
  logic [7:0] dout_q;
  logic       doe_q;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      dout_q <= 8'h00;
      doe_q  <= 1'b0;
    end else begin
      doe_q  <= 1'b0;
      dout_q <= 8'h00;
      if (id_read) begin
        doe_q <= 1'b1;
        if (addr == EHFP_ID_MAKER_ADDR) begin
          dout_q <= EHFP_ID_MAKER;
        end else if (addr == EHFP_ID_DEV_ADDR) begin
          dout_q <= EHFP_ID_DEV;
        end
      end else if (mode_q && armed_q && prog_s_q[1] && ea_s_q[1]
                   && cmd == EHFP_CMD_VERIFY) begin
        doe_q <= 1'b1;
        // Busy reads show complemented bits 7 and 3 of the byte loaded
        if (st_q == EHFP_BUSY) begin
          dout_q <= {~op_data_q[7], 3'h0, ~op_data_q[3], 3'h0};
        end else if (lock_q != 3'h0) begin
          dout_q <= 8'h00;
        end else begin
          dout_q <= mem_q[idx];
        end
      end
    end
  end

  assign PINS.port_zero_d    = dout_q;
  assign PINS.port_zero_d_oe = doe_q;
  // Ready high when idle; low while an operation runs
  assign PINS.ready_busy     = st_q != EHFP_BUSY;
  assign OSC_EN              = mode_q;
  assign CORE_RESET          = mode_q;
  assign MODE_ACTIVE         = mode_q;
  assign ARMED               = armed_q;
  assign LOCK_BITS           = lock_q;
  assign REMAP_BITS          = remap_q;
endmodule

//--- logic/ehfp_host.sv
/*
  Host end: turns user requests into pin sequences (enter, identify,
  pulse commands, verify) and returns read data. Assumes the device end
  answers on the shared pin bundle.
*/
`timescale 1ns/100ps
module ehfp_host
  import ehfp_pkg::*;
#(
  parameter int PHASE_CYCLES = 8
) (
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  ehfp_if.host             PINS,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [3:0]  REQ_CMD,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic [7:0]  REQ_DATA,
  input  wire logic        MODE_ON,
  output logic             RSP_VALID,
  output logic [7:0]       RSP_DATA
);
  typedef enum logic [2:0] {EHH_IDLE, EHH_SETUP, EHH_PULSE, EHH_WAITBUSY,
                            EHH_WAITRDY, EHH_READ} ehfp_hstate_t;

  ehfp_hstate_t st_q;
  logic [7:0]  cnt_q;
  logic [3:0]  cmd_q;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic        prog_q, data_oe_q, rsp_q;
  logic [7:0]  rsp_data_q;
  logic [1:0]  rdy_s_q;
  logic [7:0]  p0_a_q, p0_b_q;
  logic        is_read;
  logic        legal;

  assign is_read = REQ_CMD == EHFP_CMD_ID || REQ_CMD == EHFP_CMD_VERIFY;
  // Codes outside the command table are dropped here, never put on the pins
  assign legal = REQ_CMD inside {EHFP_CMD_ID, EHFP_CMD_CHIP, EHFP_CMD_BLOCK, EHFP_CMD_SECTOR,
                                 EHFP_CMD_BYTE, EHFP_CMD_BURST, EHFP_CMD_VERIFY, EHFP_CMD_SB1,
                                 EHFP_CMD_SB2, EHFP_CMD_SB3, EHFP_CMD_RB0, EHFP_CMD_RB1};

  // Synchronise ready/busy and the data bus
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rdy_s_q <= 2'h3;
      p0_a_q  <= 8'h00;
      p0_b_q  <= 8'h00;
    end else begin
      rdy_s_q <= {rdy_s_q[0], PINS.ready_busy};
      p0_a_q  <= PINS.port_zero;
      p0_b_q  <= p0_a_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin sequencer; only legal codes are driven
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      st_q       <= EHH_IDLE;
      cnt_q      <= 8'h00;
      cmd_q      <= EHFP_CMD_VERIFY;  // Not identify, so mode entry alone never arms before the first identify
      addr_q     <= 16'h0000;
      data_q     <= 8'h00;
      prog_q     <= 1'b1;
      data_oe_q  <= 1'b0;
      rsp_q      <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      rsp_q <= 1'b0;
      case (st_q)
        EHH_IDLE: begin
          if (REQ_VALID && MODE_ON && legal) begin
            cmd_q     <= REQ_CMD;
            addr_q    <= REQ_ADDR;
            data_q    <= REQ_DATA;
            data_oe_q <= !is_read;
            cnt_q     <= 8'(PHASE_CYCLES);
            st_q      <= is_read ? EHH_READ : EHH_SETUP;
          end
        end
        EHH_SETUP: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            prog_q <= 1'b0;
            cnt_q  <= 8'(PHASE_CYCLES);
            st_q   <= EHH_PULSE;
          end
        end
        EHH_PULSE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            prog_q <= 1'b1;
            cnt_q  <= 8'(PHASE_CYCLES);
            st_q   <= EHH_WAITBUSY;
          end
        end
        EHH_WAITBUSY: begin
          // Busy may never show for a refused command, so give up after a while
          cnt_q <= cnt_q - 8'h01;
          if (!rdy_s_q[1]) begin
            st_q <= EHH_WAITRDY;
          end else if (cnt_q == 8'h00) begin
            data_oe_q <= 1'b0;
            st_q      <= EHH_IDLE;
          end
        end
        EHH_WAITRDY: begin
          if (rdy_s_q[1]) begin
            data_oe_q <= 1'b0;
            st_q      <= EHH_IDLE;
          end
        end
        EHH_READ: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            rsp_q      <= 1'b1;
            rsp_data_q <= p0_b_q;
            st_q       <= EHH_IDLE;
          end
        end
        default: st_q <= EHH_IDLE;
      endcase
    end
  end

  // Pin drive; the reset pin and strobe follow the mode request
  assign PINS.rst_pin            = MODE_ON;
  assign PINS.host_mode_strobe_n = !MODE_ON;
  assign PINS.prog_pulse_n       = prog_q;
  assign PINS.ext_access_n       = 1'b1;
  assign PINS.port_one           = addr_q[7:0];
  assign PINS.port_two           = {cmd_q[1], cmd_q[0], addr_q[13:8]};
  assign PINS.port_three_in      = {cmd_q[3], cmd_q[2], addr_q[15], addr_q[14], 4'h0};
  assign PINS.port_zero_h        = data_q;
  assign PINS.port_zero_h_oe     = data_oe_q;
  assign REQ_READY               = st_q == EHH_IDLE && MODE_ON;
  assign RSP_VALID               = rsp_q;
  assign RSP_DATA                = rsp_data_q;
endmodule

//--- tb/ehfp_assertions.sv
/*
  Checker for the pin bundle between host and device ends.
  Assumes one clock, synchronous active-low reset, and a host end that
  keeps to the legal pin codes.
*/
`timescale 1ns/100ps
module ehfp_assertions
  import ehfp_pkg::*;
#(
  parameter int OP_CYCLES = 20
) (
  input wire logic       SYS_CLK,
  input wire logic       NRST,
  input wire logic       rst_pin,
  input wire logic       host_mode_strobe_n,
  input wire logic       prog_pulse_n,
  input wire logic       ext_access_n,
  input wire logic [7:0] port_one,
  input wire logic [7:0] port_two,
  input wire logic [7:0] port_three_in,
  input wire logic       ready_busy,
  input wire logic [7:0] port_zero_d,
  input wire logic       port_zero_d_oe
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]  cmd;
  logic [15:0] addr;
  logic        in_mode;
  logic        rd_ok;
  logic [15:0] low_q;
  logic        arm_q;

  // Decoded pin fields; reads need pulse high and an idle device
  assign cmd     = {port_three_in[7:6], port_two[7:6]};
  assign addr    = {port_three_in[5:4], port_two[5:0], port_one};
  assign in_mode = rst_pin && !host_mode_strobe_n;
  assign rd_ok   = in_mode && ext_access_n && prog_pulse_n && ready_busy;

  // Busy length counter, cleared whenever ready shows
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || ready_busy) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end

  // Arming as seen on the pins; the device follows a few cycles later
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !in_mode) begin
      arm_q <= 1'b0;
    end else if (ext_access_n && prog_pulse_n && cmd == EHFP_CMD_ID) begin
      arm_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  property p_rb_reset;
    $rose(NRST) |-> ready_busy && !port_zero_d_oe;
  endproperty
  a_rb_reset: assert property (p_rb_reset)
    else $error("ready or data drive wrong after reset");

  // Eight samples cover the two-flop sync plus output register
  property p_exit;
    (!in_mode)[*8] |-> !port_zero_d_oe && ready_busy;
  endproperty
  a_exit: assert property (p_exit)
    else $error("device still active outside mode");

  property p_id_maker;
    (rd_ok && cmd == EHFP_CMD_ID && addr == EHFP_ID_MAKER_ADDR)[*8]
      |-> port_zero_d_oe && port_zero_d == EHFP_ID_MAKER;
  endproperty
  a_id_maker: assert property (p_id_maker)
    else $error("maker byte not driven");

  property p_id_dev;
    (rd_ok && cmd == EHFP_CMD_ID && addr == EHFP_ID_DEV_ADDR)[*8]
      |-> port_zero_d_oe && port_zero_d == EHFP_ID_DEV;
  endproperty
  a_id_dev: assert property (p_id_dev)
    else $error("device byte not driven");

  property p_verify;
    (rd_ok && arm_q && cmd == EHFP_CMD_VERIFY)[*8] |-> port_zero_d_oe;
  endproperty
  a_verify: assert property (p_verify)
    else $error("verify data not driven");

  property p_no_drive;
    (!prog_pulse_n || (cmd != EHFP_CMD_ID && cmd != EHFP_CMD_VERIFY))[*8]
      |-> !port_zero_d_oe;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("data bus driven during a write code");

  property p_busy_cause;
    $fell(ready_busy) |-> !$past(prog_pulse_n, 2) && in_mode;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without a program pulse");

  // Aborted operations are left out: only completions in mode count
  property p_busy_len;
    $rose(ready_busy) && in_mode |-> low_q == OP_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");

  c_id: cover property (port_zero_d_oe && port_zero_d == EHFP_ID_MAKER);
  c_done: cover property ($rose(ready_busy));
  c_exit: cover property ($rose(host_mode_strobe_n));
endmodule

//--- tb/ext_host_flash_prog_port_tb.sv
/*
  Testbench: host end facing device end, driven from the host request
  side with a fixed seed. Assumes the package constants and short timings.
*/
`timescale 1ns/100ps
module ext_host_flash_prog_port_tb
  import ehfp_pkg::*;
;
  localparam int OPC = 20;
  localparam int TMO = 30000;
  logic        clk, nrst, req_valid, mode_on, arm_m;
  logic [3:0]  req_cmd;
  logic [15:0] req_addr, a;
  logic [7:0]  req_data, rd;
  wire logic   req_ready, rsp_valid, osc_en, core_reset, mode_active, armed;
  wire logic [7:0] rsp_data;
  wire logic [2:0] lock_bits;
  wire logic [1:0] remap_bits;
  logic [7:0]  mem [64];
  logic [2:0]  lk;
  logic [1:0]  rm;
  logic [3:0]  lcode [5] = '{EHFP_CMD_RB0, EHFP_CMD_RB1, EHFP_CMD_SB1, EHFP_CMD_SB2, EHFP_CMD_SB3};
  logic [3:0]  bad [4] = '{4'h2, 4'h4, 4'h7, 4'hA};
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ehfp_if u_ehfp_if ();
  ehfp_device #(.OP_CYCLES(OPC), .MEM_DEPTH(64)) u_ehfp_device (
    .SYS_CLK(clk), .NRST(nrst), .PINS(u_ehfp_if.device), .OSC_EN(osc_en),
    .CORE_RESET(core_reset), .MODE_ACTIVE(mode_active), .ARMED(armed),
    .LOCK_BITS(lock_bits), .REMAP_BITS(remap_bits));
  ehfp_host #(.PHASE_CYCLES(8)) u_ehfp_host (
    .SYS_CLK(clk), .NRST(nrst), .PINS(u_ehfp_if.host), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_CMD(req_cmd), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
    .MODE_ON(mode_on), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  ehfp_assertions #(.OP_CYCLES(OPC)) u_ehfp_assertions (
    .SYS_CLK(clk), .NRST(nrst), .rst_pin(u_ehfp_if.rst_pin),
    .host_mode_strobe_n(u_ehfp_if.host_mode_strobe_n), .prog_pulse_n(u_ehfp_if.prog_pulse_n),
    .ext_access_n(u_ehfp_if.ext_access_n), .port_one(u_ehfp_if.port_one),
    .port_two(u_ehfp_if.port_two), .port_three_in(u_ehfp_if.port_three_in),
    .ready_busy(u_ehfp_if.ready_busy), .port_zero_d(u_ehfp_if.port_zero_d),
    .port_zero_d_oe(u_ehfp_if.port_zero_d_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected flash contents; only taken once the model is armed
  function automatic void apply(input logic [3:0] c, input logic [15:0] ad, input logic [7:0] d);
    if (!arm_m) return;
    case (c)
      EHFP_CMD_CHIP: begin
        foreach (mem[i]) mem[i] = 8'hFF;
        lk = 3'h0;
        rm = 2'h0;
      end
      EHFP_CMD_BLOCK, EHFP_CMD_SECTOR: if (lk == 3'h0 && !ad[15]) foreach (mem[i]) mem[i] = 8'hFF;
      EHFP_CMD_BYTE, EHFP_CMD_BURST: if (lk == 3'h0) mem[ad[5:0]] = d;
      EHFP_CMD_SB1: lk[0] = 1'b1;
      EHFP_CMD_SB2: lk[1] = 1'b1;
      EHFP_CMD_SB3: lk[2] = 1'b1;
      EHFP_CMD_RB0: rm[0] = 1'b1;
      EHFP_CMD_RB1: rm[1] = 1'b1;
      default: ;
    endcase
  endfunction

  function automatic logic [7:0] exp_id(input logic [15:0] ad);
    if (ad == EHFP_ID_MAKER_ADDR) return EHFP_ID_MAKER;
    if (ad == EHFP_ID_DEV_ADDR) return EHFP_ID_DEV;
    return 8'h00;
  endfunction

  // Locked parts read back as zero
  function automatic logic [7:0] exp_ver(input logic [15:0] ad);
    return (lk != 3'h0) ? 8'h00 : mem[ad[5:0]];
  endfunction

  task automatic wait_idle();
    int n;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (req_ready === 1'b1) break;
    end
    if (n == 400) begin
      err_count++;
      final_report();
    end
  endtask

  // One host request; valid held until the edge that takes it
  task automatic op(input logic [3:0] c, input logic [15:0] ad, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    wait_idle();
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= ad;
    req_data <= d;
    wait_idle();
    @(posedge clk);
    req_valid <= 1'b0;
    r = 8'h00;
    if (c == EHFP_CMD_ID || c == EHFP_CMD_VERIFY) begin
      for (n = 0; n < 100; n++) begin
        @(negedge clk);
        if (rsp_valid === 1'b1) break;
      end
      if (n == 100) begin
        err_count++;
        final_report();
      end
      r = rsp_data;
      if (c == EHFP_CMD_ID) arm_m = 1'b1;
    end else begin
      apply(c, ad, d);
      repeat (2) @(negedge clk);
      wait_idle();
    end
  endtask

  task automatic set_mode(input logic on);
    @(posedge clk);
    mode_on <= on;
    repeat (8) @(negedge clk);
    if (!on) arm_m = 1'b0;
  endtask

  // Program eight spread addresses, apply one command, read all back
  task automatic prog_pass(input logic [3:0] ec, input logic [15:0] ea);
    logic [15:0] av [8];
    logic [7:0]  r;
    for (int i = 0; i < 8; i++) begin
      av[i] = {1'b0, 9'($urandom), 6'(i * 7 + 1)};
      op(i[0] ? EHFP_CMD_BURST : EHFP_CMD_BYTE, av[i], 8'($urandom), r);
    end
    op(ec, ea, 8'h00, r);
    for (int i = 0; i < 8; i++) begin
      op(EHFP_CMD_VERIFY, av[i], 8'h00, r);
      chk(r, exp_ver(av[i]));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h809E));
    nrst = 1'b0;
    req_valid = 1'b0;
    mode_on = 1'b0;
    req_cmd = 4'h0;
    req_addr = 16'h0000;
    req_data = 8'h00;
    arm_m = 1'b0;
    lk = 3'h0;
    rm = 2'h0;
    foreach (mem[i]) mem[i] = 8'hFF;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({7'h00, mode_active}, 8'h00);
    set_mode(1'b1);
    chk({5'h00, mode_active, osc_en, core_reset}, 8'h07);
    // Write before arming must be dropped
    op(EHFP_CMD_BYTE, 16'h0005, 8'h3C, rd);
    chk({7'h00, armed}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? {8'h01, 8'($urandom)} : EHFP_ID_MAKER_ADDR + 16'(i);
      op(EHFP_CMD_ID, a, 8'h00, rd);
      chk(rd, exp_id(a));
    end
    chk({7'h00, armed}, 8'h01);
    op(EHFP_CMD_VERIFY, 16'h0005, 8'h00, rd);
    chk(rd, exp_ver(16'h0005));
    foreach (bad[k]) op(bad[k], 16'h0006, 8'h00, rd);
    op(EHFP_CMD_VERIFY, 16'h0006, 8'h00, rd);
    chk(rd, exp_ver(16'h0006));
    prog_pass(EHFP_CMD_VERIFY, 16'h0000);
    foreach (lcode[k]) begin
      op(lcode[k], 16'h0000, 8'h00, rd);
      chk({3'h0, lock_bits, remap_bits}, {3'h0, lk, rm});
    end
    // Locked: program and erase refused, reads give zero
    op(EHFP_CMD_BYTE, 16'h0001, 8'h00, rd);
    op(EHFP_CMD_BLOCK, 16'h0000, 8'h00, rd);
    op(EHFP_CMD_VERIFY, 16'h0001, 8'h00, rd);
    chk(rd, exp_ver(16'h0001));
    op(EHFP_CMD_CHIP, 16'h0000, 8'h00, rd);
    chk({3'h0, lock_bits, remap_bits}, 8'h00);
    prog_pass(EHFP_CMD_BLOCK, 16'h0000);
    prog_pass(EHFP_CMD_SECTOR, 16'h0100);
    prog_pass(EHFP_CMD_BLOCK, 16'hF000);
    set_mode(1'b0);
    chk({4'h0, mode_active, osc_en, core_reset, armed}, 8'h00);
    set_mode(1'b1);
    chk({7'h00, armed}, 8'h00);
    set_mode(1'b0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({7'h00, mode_active}, 8'h00);
    final_report();
  end
endmodule
